// ### rtl/iecb_bank.sv
// Clear-enable register bank for interrupt lines 96 to 127
//
// Contract
// - Bits 31..3 map lines 127..99, bit0 line 96
// - Writing one disables only that line unless a set request for it comes in the same cycle
// - Writing zero leaves line enable unchanged
// - Read returns each line's present enable state
`timescale 1ns/1ps
`include "iecb_defines.svh"

module iecb_bank
    import iecb_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [`IECB_ADDR_W-1:0]   reg_addr,
    input  wire logic [`IECB_DATA_W-1:0]   reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [`IECB_DATA_W-1:0]   reg_rdata,
    input  wire logic [`IECB_DATA_W-1:0]   set_enable_req,
    input  wire logic [`IECB_DATA_W-1:0]   irq_line_in,
    output logic      [`IECB_DATA_W-1:0]   irq_enable,
    output logic      [`IECB_DATA_W-1:0]   irq_active
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    localparam iecb_word_t impl_mask = `IECB_IMPL_MASK;

    iecb_sel_t  sel;
    iecb_word_t clr_req;
    iecb_word_t enable_vec;

    always_comb
    begin
        unique case (reg_addr)
            `IECB_OFF_CLR_UPPER: sel = IECB_SEL_CLR_UPPER;
            `IECB_OFF_ACTIVE:    sel = IECB_SEL_ACTIVE;
            default:             sel = IECB_SEL_NONE;
        endcase
    end

    // Only bits that serve a line turn a written one into a clear
    always_comb
    begin
        if (reg_write && (sel == IECB_SEL_CLR_UPPER))
        begin
            clr_req = reg_wdata & `IECB_IMPL_MASK;
        end
        else
        begin
            clr_req = '0;
        end
    end

    // ****************************************************************
    // Per-line enable state
    // ****************************************************************
    // The set path comes from the companion set-enable bank on this
    // clock, so it needs no synchroniser.
    for (genvar i = 0; i < `IECB_DATA_W; i++)
    begin : g_line
        iecb_enable_cell
        #(
            .IMPLEMENTED (impl_mask[i])
        )
        u_cell
        (
            .clock   (clock),
            .rst     (rst),
            .set_req (set_enable_req[i]),
            .clr_req (clr_req[i]),
            .enable  (enable_vec[i])
        );
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    iecb_bus_state_t st_ff;
    iecb_bus_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // Data stand only in the cycle after the strobe
        nxt_st.rdata_ff = `IECB_RST_RDATA;
        if (reg_read)
        begin
            unique case (sel)
                IECB_SEL_CLR_UPPER:
                    nxt_st.rdata_ff = enable_vec & `IECB_IMPL_MASK;
                IECB_SEL_ACTIVE:
                    nxt_st.rdata_ff = enable_vec & irq_line_in
                                      & `IECB_IMPL_MASK;
                IECB_SEL_NONE:
                    nxt_st.rdata_ff = `IECB_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st_ff.rdata_ff <= `IECB_RST_RDATA;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata  = st_ff.rdata_ff;
    assign irq_enable = enable_vec;
    // Gated requests to the priority logic; unregistered to add no latency
    assign irq_active = enable_vec & irq_line_in;

endmodule

// ### rtl/iecb_defines.svh
// Offsets, field layout and reset values of the clear-enable bank 96..127
`ifndef IECB_DEFINES_SVH
`define IECB_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define IECB_ADDR_W          8
`define IECB_OFF_CLR_UPPER   8'h00
`define IECB_OFF_ACTIVE      8'h04

// ****************************************************************
// Field layout
// ****************************************************************
`define IECB_DATA_W          32
`define IECB_IRQ_BASE        96
`define IECB_IMPL_MASK       32'hffff_fff9
`define IECB_RSVD_HI         2
`define IECB_RSVD_LO         1

// ****************************************************************
// Reset values
// ****************************************************************
`define IECB_RST_ENABLE      32'h0000_0000
`define IECB_RST_RDATA       32'h0000_0000

`endif

// ### rtl/iecb_enable_cell.sv
// One interrupt line's enable flip-flop with set and clear requests
`timescale 1ns/1ps
`include "iecb_defines.svh"

module iecb_enable_cell
    import iecb_pkg::*;
#(
    parameter bit IMPLEMENTED = 1'b1
)
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic set_req,
    input  wire logic clr_req,
    output logic      enable
);

    iecb_cell_state_t st_ff;
    iecb_cell_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (!IMPLEMENTED)
        begin
            nxt_st.enable_ff = 1'b0;
        end
        else if (set_req)
        begin
            // Set wins so a concurrent enable is never lost
            nxt_st.enable_ff = 1'b1;
        end
        else if (clr_req)
        begin
            nxt_st.enable_ff = 1'b0;
        end
        // No request: state held, so a written zero changes nothing
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st_ff.enable_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign enable = st_ff.enable_ff;

endmodule

// ### rtl/iecb_pkg.sv
// Types shared by the clear-enable bank files
package iecb_pkg;

    typedef logic [31:0] iecb_word_t;

    typedef enum logic [1:0]
    {
        IECB_SEL_NONE,
        IECB_SEL_CLR_UPPER,
        IECB_SEL_ACTIVE
    } iecb_sel_t;

    // State of the bus side of the bank
    typedef struct packed
    {
        iecb_word_t rdata_ff;
    } iecb_bus_state_t;

    // State of one interrupt line's enable
    typedef struct packed
    {
        logic enable_ff;
    } iecb_cell_state_t;

endpackage

// ### verif/iecb_bank_properties.sv
// Port checks for the clear-enable bank
`timescale 1ns/1ps
module iecb_bank_properties
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] set_enable_req,
    input wire logic [31:0] irq_line_in,
    input wire logic [31:0] irq_enable,
    input wire logic [31:0] irq_active
);
    localparam logic [31:0] impl_mask = 32'hffff_fff9;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_set_maps_bit: assert property (|set_enable_req |=>
        (irq_enable & $past(set_enable_req) & impl_mask)
        == ($past(set_enable_req) & impl_mask)) else $error("set lost");
    a_write_one_clears: assert property (reg_write
        && reg_addr == 8'h00 && set_enable_req == 32'h0
        |=> (irq_enable & $past(reg_wdata)) == 32'h0)
        else $error("clear lost");
    a_write_zero_keeps: assert property (reg_write
        && reg_addr == 8'h00 && set_enable_req == 32'h0
        |=> irq_enable == ($past(irq_enable) & ~$past(reg_wdata)))
        else $error("bad keep");
    a_read_state: assert property (reg_read && reg_addr == 8'h00 |=>
        reg_rdata == ($past(irq_enable) & impl_mask)) else $error("bad read");
    a_unused_zero: assert property (irq_enable[2:1] == 2'h0
        && reg_rdata[2:1] == 2'h0) else $error("unused bit set");
    a_reset_off: assert property ($past(rst) |-> irq_enable == 32'h0)
        else $error("enable after reset");
    a_active_gated: assert property ((irq_active
        & ~(irq_enable & irq_line_in)) == 32'h0)
        else $error("active not gated");
endmodule
bind iecb_bank iecb_bank_properties u_iecb_bank_properties
(
    .clock          (clock),
    .rst            (rst),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_write      (reg_write),
    .reg_read       (reg_read),
    .reg_rdata      (reg_rdata),
    .set_enable_req (set_enable_req),
    .irq_line_in    (irq_line_in),
    .irq_enable     (irq_enable),
    .irq_active     (irq_active)
);

// ### verif/tb.sv
// Directed bench for the clear-enable bank
`timescale 1ns/1ps
module tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] set_enable_req = 32'h0;
    logic [31:0] irq_line_in = 32'h0;
    logic [31:0] reg_rdata, irq_enable, irq_active, e;
    int          err_count = 0, checks_done = 0, cyc = 0;
    always #12.5 clock = ~clock;
    iecb_bank u_iecb_bank
    (
        .clock          (clock),
        .rst            (rst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_write      (reg_write),
        .reg_read       (reg_read),
        .reg_rdata      (reg_rdata),
        .set_enable_req (set_enable_req),
        .irq_line_in    (irq_line_in),
        .irq_enable     (irq_enable),
        .irq_active     (irq_active)
    );
    // ************************************************
    // Bus tasks and scenarios
    // ************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic set_all;
        @(posedge clock);
        set_enable_req <= 32'hffff_ffff;
        @(posedge clock);
        set_enable_req <= 32'h0;
        #1;
        chk(irq_enable, 32'hffff_fff9);
    endtask
    task automatic t_clear_keep;
        set_all();
        wr(8'h00, 32'h8000_0001);
        chk(irq_enable, 32'h7fff_fff8);
        wr(8'h00, 32'h0);
        chk(irq_enable, 32'h7fff_fff8);
        rd(8'h00, 32'h7fff_fff8);
    endtask
    task automatic t_walk;
        set_all();
        e = 32'hffff_fff9;
        for (int i = 31; i >= 0; i--)
        begin
            wr(8'h00, 32'h1 << i);
            e = e & ~(32'h1 << i);
            rd(8'h00, e);
        end
    endtask
    task automatic t_refused;
        set_all();
        irq_line_in <= 32'h0000_f00f;
        wr(8'h10, 32'hffff_ffff);
        wr(8'h04, 32'hffff_ffff);
        chk(irq_enable, 32'hffff_fff9);
        chk(irq_active, 32'h0000_f009);
        rd(8'h04, 32'h0000_f009);
        rd(8'h10, 32'h0);
    endtask
    task automatic t_reset_state;
        chk(irq_enable, 32'h0);
        chk(irq_active, 32'h0);
        rd(8'h00, 32'h0);
    endtask
    // Reset with every implemented line enabled and irq_line_in still at 32'h0000_f00f, so it must really clear
    task automatic t_mid_reset;
        set_all();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        t_reset_state();
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1;
        t_reset_state();
        t_clear_keep();
        t_walk();
        t_refused();
        t_mid_reset();
        stop_test();
    end
endmodule
